// ### dv/rslc_master_model.sv
// partner: bus master that sends queries and collects replies
// assumes a fixed bit time in clock cycles and a line idle high
`timescale 1ns/1ps
module rslc_master_model #(
  parameter int BIT = 2170
) (
  input wire logic clk_in,
  output logic txd_out,
  input wire logic rxd_in
);
  // ----------------------------------------------------------------
  // query sender and reply collector
  // ----------------------------------------------------------------
  logic [7:0] rx_q[$];
  int stop_bad = 0;

  initial txd_out = 1'b1;

  // one stop bit only: the shortest form the device must take
  task automatic send_frame(input logic [7:0] b[$]);
    foreach (b[i]) begin
      for (int k = 0; k < 10; k++) begin
        @(posedge clk_in);
        txd_out <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : b[i][k - 1];
        repeat (BIT - 1) @(posedge clk_in);
      end
    end
  endtask

  initial begin
    logic [7:0] d;
    forever begin
      @(negedge rxd_in);
      repeat (BIT / 2) @(posedge clk_in);
      for (int k = 0; k < 8; k++) begin
        repeat (BIT) @(posedge clk_in);
        d[k] = rxd_in;
      end
      repeat (BIT) @(posedge clk_in);
      if (!rxd_in) stop_bad++;
      repeat (BIT) @(posedge clk_in);
      if (!rxd_in) stop_bad++;
      rx_q.push_back(d);
    end
  end
endmodule // rslc_master_model

// ### dv/rslc_top_asserts.sv
// checker: port-level assertions for the rs-485 slave link controller
// assumes one clock domain; the fastest rate gives the shortest bit
`timescale 1ns/1ps
module rslc_top_asserts
  import rslc_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic IRQ_OUT,
  input wire logic RXD_IN,
  input wire logic TXD_OUT,
  input wire logic DE_OUT,
  input wire logic WRITE_OK_OUT,
  input wire logic FRAME_ADDR_OK_OUT
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // rate not visible here, so bounds use the shortest legal bit
  localparam int BIT_MIN = CLK_HZ / 115200 - 1;
  localparam int GAP_MIN = 3 * CHAR_BITS * BIT_MIN;
  logic txd_q;
  logic [19:0] run_cnt;
  logic [19:0] idle_cnt;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      txd_q <= 1'b1;
      run_cnt <= 20'h00000;
      idle_cnt <= 20'h00000;
    end else begin
      txd_q <= TXD_OUT;
      if (TXD_OUT != txd_q) begin
        run_cnt <= 20'h00001;
      end else if (run_cnt != 20'hfffff) begin
        run_cnt <= run_cnt + 20'h00001;
      end
      if (!RXD_IN) begin
        idle_cnt <= 20'h00000;
      end else if (idle_cnt != 20'hfffff) begin
        idle_cnt <= idle_cnt + 20'h00001;
      end
    end
  end

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  AST_RDATA_IDLE: assert property (!$past(RD_IN) |-> RDATA_OUT == READ_ZERO)
    else $error("read data outside its slot");
  AST_UNMAPPED: assert property (RD_IN && ADDR_IN > REG_TXGO |=> RDATA_OUT == READ_ZERO)
    else $error("unmapped read not zero");
  AST_TXD_IDLE: assert property (!DE_OUT |-> TXD_OUT)
    else $error("line driven without enable");
  AST_DE_FALL: assert property ($fell(DE_OUT) |-> $past(TXD_OUT) && run_cnt >= 2 * BIT_MIN)
    else $error("enable dropped before two stop bits");
  AST_BIT_LEN: assert property (DE_OUT && TXD_OUT != txd_q |-> run_cnt >= BIT_MIN)
    else $error("bit shorter than fastest rate");
  AST_WRITE_OK: assert property ($changed(WRITE_OK_OUT) |->
    ($past(WR_IN) && $past(ADDR_IN) == REG_CTRL) || ($past(WR_IN, 2) && $past(ADDR_IN, 2) == REG_CTRL))
    else $error("write permit moved without control write");
  AST_ADDR_GAP: assert property ($changed(FRAME_ADDR_OK_OUT) |-> idle_cnt >= GAP_MIN)
    else $error("match flag moved inside a frame");
  AST_IRQ_MASKED: assert property (WR_IN && ADDR_IN == REG_MASK && WDATA_IN[5:0] == 6'h00
    |-> ##2 !IRQ_OUT)
    else $error("interrupt not masked");
endmodule // rslc_top_asserts

bind rslc_top rslc_top_asserts chk_u (
  .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .IRQ_OUT(IRQ_OUT), .RXD_IN(RXD_IN),
  .TXD_OUT(TXD_OUT), .DE_OUT(DE_OUT), .WRITE_OK_OUT(WRITE_OK_OUT),
  .FRAME_ADDR_OK_OUT(FRAME_ADDR_OK_OUT));

// ### dv/test_rs485_slave_link_control.sv
// bench: register checks, query frames and one reply against integer expectations
// assumes rslc_top, the master model and the bound checker
`timescale 1ns/1ps
module test_rs485_slave_link_control;
  import rslc_pkg::*;
  localparam int BIT = CLK_HZ / 115200;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, v;
  logic irq, rxd, txd, de, alarm, wok, aok;
  logic [7:0] txb;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 32'h505d96b5;
  int stn;

  rslc_top dut_u (.CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq), .RXD_IN(rxd), .TXD_OUT(txd),
    .DE_OUT(de), .ALARM_OUT(alarm), .WRITE_OK_OUT(wok), .FRAME_ADDR_OK_OUT(aok));
  rslc_master_model #(.BIT(BIT)) mdl_u (.clk_in(clk), .txd_out(rxd), .rxd_in(txd));

  // ----------------------------------------------------------------
  // clock, watchdog, checking and bus tasks
  // ----------------------------------------------------------------
  initial forever #2 clk = ~clk;

  task automatic conclude();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // four frames of a few characters plus one reply fit well inside
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 700000) begin
      fails++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(negedge clk);
    check(irq, e);
  endtask

  task automatic frame(input int a, input int f, input int len, input int st, input int rem);
    logic [7:0] q[$];
    int hit;
    int refd;
    q.push_back(8'(a));
    if (len > 1) q.push_back(8'(f));
    hit = (a == 0 || a == (st == 0 ? 255 : st));
    refd = hit && len > 1 && !rem && (f == FN_WRITE1 || f == FN_WRITEN);
    wreg(REG_MASK, 32'h21);
    mdl_u.send_frame(q);
    for (int n = 0; n < 120000 && irq !== 1'b1; n++) @(posedge clk);
    wreg(REG_MASK, 32'h0);
    irq_is(1'b0);
    wreg(REG_MASK, 32'h21);
    irq_is(1'b1);
    rreg(REG_STATUS);
    check(v[5:0], hit + 2 * (len > 1) + 8 * refd + 32 * (1 - hit));
    irq_is(1'b0);
    check(aok, hit);
    rreg(REG_STATE);
    check(v[15:8], len);
    check(v[4:0], (hit && a != 0) ? 5'h04 : 5'h01);
    $display("frame %0h done", a);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wreg(REG_CTRL, (i * 16) << 16 | (i % 2) << 11 | i << 8 | (192 + 2 * i));
      rreg(REG_CTRL);
      check(v & 32'h7f0fff, (i > 6 ? 99 : i * 16) << 16 | (i % 2) << 11 | i << 8
        | (i > 3 ? 199 : 192 + 2 * i));
      check(wok, i % 2);
    end
    for (int i = 0; i < 6; i++) begin
      wreg(REG_DELAY, i);
      rreg(REG_DELAY);
      check(v[2:0], i);
    end
    wreg(4'h8 | 4'($random(seed)), 32'hffffffff);
    rreg(4'hf);
    check(v, READ_ZERO);
    $display("register test done");
    stn = 1 + {$random(seed)} % 199;
    wreg(REG_CTRL, 7 << 8 | stn);
    wreg(REG_DELAY, 0);
    frame(stn, FN_WRITE1, 2, stn, 0);
    txb = 8'($random(seed));
    wreg(REG_TXDATA, txb);
    wreg(REG_TXGO, 1);
    for (int n = 0; n < 40000 && mdl_u.rx_q.size() == 0; n++) @(posedge clk);
    check(de, 1'b1);
    check(mdl_u.rx_q[0], txb);
    check(mdl_u.stop_bad, 0);
    wreg(REG_TXGO, 0);
    for (int n = 0; n < 4000 && de !== 1'b0; n++) @(posedge clk);
    rreg(REG_STATUS);
    check(v[5:0], 6'h10);
    $display("reply test done");
    wreg(REG_CTRL, 7 << 8 | 1 << 11 | stn);
    frame(0, FN_WRITE1, 2, stn, 1);
    check(de, 1'b0);
    frame(200 + {$random(seed)} % 55, FN_READ, 1, stn, 1);
    wreg(REG_CTRL, 7 << 8 | 1 << 11);
    frame(255, FN_READ, 1, 0, 1);
    check(alarm, 1'b0);
    conclude();
  end
endmodule // test_rs485_slave_link_control

// ### rtl/rslc_pkg.sv
// package: constants and types of the rs-485 slave link controller
// assumes a single 250 MHz clock and a plain register port
package rslc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned SEC_CYCLES = CLK_HZ;
  localparam int unsigned BIT_W = 18;
  localparam int unsigned CHAR_BITS = 11;
  localparam int unsigned GAP_HALF_CHARS = 7;
  localparam logic [7:0] MAX_ADDR = 8'hc7;
  localparam logic [7:0] SUBST_ADDR = 8'hff;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [6:0] MAX_TIMEOUT = 7'h63;
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE1 = 8'h06;
  localparam logic [7:0] FN_WRITEN = 8'h10;
  localparam logic [4:0] MAX_GROUP = 5'h10;
  localparam logic [7:0] FLEN_SHORT = 8'h08;

  // ----------------------------------------------------------------
  // register port map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_DELAY = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_MASK = 4'h3;
  localparam logic [3:0] REG_RXDATA = 4'h4;
  localparam logic [3:0] REG_TXDATA = 4'h5;
  localparam logic [3:0] REG_STATE = 4'h6;
  localparam logic [3:0] REG_TXGO = 4'h7;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  localparam int unsigned ST_W = 6;
  localparam int unsigned ST_FRAME = 0;
  localparam int unsigned ST_RXBYTE = 1;
  localparam int unsigned ST_TIMEOUT = 2;
  localparam int unsigned ST_REFUSED = 3;
  localparam int unsigned ST_TXDONE = 4;
  localparam int unsigned ST_DROP = 5;

  // per-rate bit period in clock cycles (CLK_HZ / baud)
  function automatic logic [BIT_W-1:0] bit_cycles(input logic [2:0] sel);
    int unsigned b;
    unique case (sel)
      3'h0: b = 1200;
      3'h1: b = 2400;
      3'h2: b = 4800;
      3'h3: b = 9600;
      3'h4: b = 19200;
      3'h5: b = 38400;
      3'h6: b = 57600;
      3'h7: b = 115200;
    endcase
    return BIT_W'(CLK_HZ / b);
  endfunction

  // response delay in characters
  function automatic logic [7:0] delay_chars(input logic [2:0] sel);
    unique case (sel)
      3'h1: return 8'h0a;
      3'h2: return 8'h14;
      3'h3: return 8'h32;
      3'h4: return 8'h64;
      3'h5: return 8'hc8;
      default: return 8'h00;
    endcase
  endfunction

  typedef struct packed {
    logic [7:0] station;
    logic [2:0] baud;
    logic remote_en;
    logic [6:0] timeout_s;
    logic [2:0] resp_delay;
  } rslc_cfg_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rslc_byte_type;

endpackage

// ### rtl/rslc_rx.sv
// byte receiver: 8 data bits, no parity, one stop bit checked
// assumes rxd already synchronous to the clock
`timescale 1ns/1ps
module rslc_rx
  import rslc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [BIT_W-1:0] bit_cyc_in,
  input wire logic rxd_in,
  output rslc_pkg::rslc_byte_type byte_out,
  output logic busy_out
);
  import rslc_pkg::*;

  logic [BIT_W-1:0] cnt_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic act_r;

  // ----------------------------------------------------------------
  // sampling at mid-bit
  // ----------------------------------------------------------------
  // only one stop bit is checked, so one or two stop bits both pass
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r <= '0;
      bit_r <= '0;
      sh_r <= '0;
      act_r <= 1'b0;
      byte_out <= '0;
    end else begin
      byte_out.valid <= 1'b0;
      if (!act_r) begin
        if (!rxd_in) begin
          act_r <= 1'b1;
          cnt_r <= bit_cyc_in >> 1;
          bit_r <= '0;
        end
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end else begin
        cnt_r <= bit_cyc_in - 1'b1;
        bit_r <= bit_r + 1'b1;
        if (bit_r == 4'h0 && rxd_in) begin
          act_r <= 1'b0;
        end else if (bit_r >= 4'h1 && bit_r <= 4'h8) begin
          sh_r <= {rxd_in, sh_r[7:1]};
        end else if (bit_r == 4'h9) begin
          act_r <= 1'b0;
          byte_out.valid <= rxd_in;
          byte_out.data <= sh_r;
        end
      end
    end
  end

  assign busy_out = act_r;
endmodule // rslc_rx

// ### rtl/rslc_top.sv
// rs-485 slave link control: framing, address filter, supervision, reply pacing
// assumes software parses frame bodies via the register port
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module rslc_top
  import rslc_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  output logic IRQ_OUT,
  input wire logic RXD_IN,
  output logic TXD_OUT,
  output logic DE_OUT,
  output logic ALARM_OUT,
  output logic WRITE_OK_OUT,
  output logic FRAME_ADDR_OK_OUT
);
  import rslc_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_RECV = 4'b0010,
    S_HOLD = 4'b0100,
    S_SEND = 4'b1000
  } rslc_state_type;

  rslc_cfg_type cfg_r;
  rslc_byte_type rx_byte;
  rslc_state_type state_r;
  logic [ST_W-1:0] status_r;
  logic [ST_W-1:0] mask_r;
  logic [ST_W-1:0] ev;
  logic [BIT_W-1:0] bit_cyc;
  logic [BIT_W+3:0] char_cyc;
  logic [31:0] gap_cnt_r;
  logic [31:0] sup_cnt_r;
  logic [6:0] sec_cnt_r;
  logic [7:0] dly_chars_r;
  logic [7:0] rx_data_r;
  logic [7:0] first_r;
  logic [7:0] func_r;
  logic [7:0] nbytes_r;
  logic [7:0] tx_data_r;
  logic tx_go_r;
  logic tx_start;
  logic tx_busy;
  logic rx_busy;
  logic addr_ok_r;
  logic bcast_r;
  logic gap_end;
  logic is_me;
  logic byte_refused;
  logic frame_end_r;

  // ----------------------------------------------------------------
  // timing derivation
  // ----------------------------------------------------------------
  assign bit_cyc = bit_cycles(cfg_r.baud);
  assign char_cyc = (BIT_W+4)'(bit_cyc) * (BIT_W+4)'(CHAR_BITS);
  // 3.5 chars counted as 7 half characters of idle line
  assign gap_end = (gap_cnt_r == 32'((char_cyc * GAP_HALF_CHARS) >> 1));

  // station 0 is replaced by 255; broadcast is always 0
  assign is_me = (cfg_r.station == '0) ? (rx_data_r == SUBST_ADDR)
                                       : (rx_data_r == cfg_r.station);

  rslc_rx u_rx (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .bit_cyc_in(bit_cyc),
    .rxd_in(RXD_IN),
    .byte_out(rx_byte),
    .busy_out(rx_busy)
  );

  rslc_tx u_tx (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .bit_cyc_in(bit_cyc),
    .start_in(tx_start),
    .data_in(tx_data_r),
    .txd_out(TXD_OUT),
    .busy_out(tx_busy)
  );

  // ----------------------------------------------------------------
  // frame state machine
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_r <= S_IDLE;
      gap_cnt_r <= '0;
      nbytes_r <= '0;
      first_r <= '0;
      func_r <= '0;
      addr_ok_r <= 1'b0;
      bcast_r <= 1'b0;
      frame_end_r <= 1'b0;
    end else begin
      frame_end_r <= 1'b0;
      if (rx_busy || rx_byte.valid) begin
        gap_cnt_r <= '0;
      end else if (!gap_end) begin
        gap_cnt_r <= gap_cnt_r + 1'b1;
      end
      unique case (state_r)
        S_IDLE: begin
          if (rx_byte.valid) begin
            state_r <= S_RECV;
            nbytes_r <= 8'h01;
          end
        end
        S_RECV: begin
          if (rx_byte.valid) begin
            nbytes_r <= nbytes_r + 1'b1;
            if (nbytes_r == 8'h01) begin
              func_r <= rx_byte.data;
            end
          end else if (gap_end) begin
            frame_end_r <= 1'b1;
            if (addr_ok_r && !bcast_r) begin
              state_r <= S_HOLD;
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
        S_HOLD: begin
          // the first hold cycle still sees the old delay and a stale count
          if (!frame_end_r && sup_cnt_r[7:0] >= dly_chars_r && tx_go_r) begin
            state_r <= S_SEND;
          end
        end
        S_SEND: begin
          if (!tx_go_r && !tx_busy) begin
            state_r <= S_IDLE;
          end
        end
      endcase
      if (state_r == S_IDLE && rx_byte.valid) begin
        first_r <= rx_byte.data;
        func_r <= '0; // one-byte frames must not reuse an old function code
        addr_ok_r <= (rx_byte.data == BCAST_ADDR) ||
                     ((cfg_r.station == '0) ? (rx_byte.data == SUBST_ADDR)
                                            : (rx_byte.data == cfg_r.station));
        bcast_r <= (rx_byte.data == BCAST_ADDR);
      end
    end
  end

  // ----------------------------------------------------------------
  // received data and remote write gating
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rx_data_r <= '0;
    end else if (rx_byte.valid) begin
      rx_data_r <= rx_byte.data;
    end
  end

  // a write frame is legal only when remote config is on
  // group writes above 16 registers are also refused
  assign byte_refused = frame_end_r && addr_ok_r &&
                        (((func_r == FN_WRITE1 || func_r == FN_WRITEN) &&
                          !cfg_r.remote_en) ||
                         (func_r == FN_WRITEN && nbytes_r > 8'(9 + 2 * MAX_GROUP)));

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      WRITE_OK_OUT <= 1'b0;
      FRAME_ADDR_OK_OUT <= 1'b0;
    end else begin
      WRITE_OK_OUT <= cfg_r.remote_en;
      if (frame_end_r) begin
        FRAME_ADDR_OK_OUT <= addr_ok_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // supervision and response delay counters
  // ----------------------------------------------------------------
  // sup_cnt_r counts characters in hold, clock cycles of each second otherwise while timeout_s is nonzero
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      sup_cnt_r <= '0;
      sec_cnt_r <= '0;
      ALARM_OUT <= 1'b0;
      dly_chars_r <= '0;
    end else begin
      if (frame_end_r) begin
        sup_cnt_r <= '0;
        sec_cnt_r <= '0;
        ALARM_OUT <= 1'b0;
        dly_chars_r <= delay_chars(cfg_r.resp_delay);
      end else if (state_r == S_HOLD) begin
        if (sup_cnt_r[31:8] == 24'(char_cyc)) begin
          sup_cnt_r <= {24'h0, sup_cnt_r[7:0] + 8'h01};
        end else if (sup_cnt_r[7:0] < dly_chars_r) begin
          sup_cnt_r <= sup_cnt_r + 32'h0000_0100;
        end
      end else if (cfg_r.timeout_s == '0) begin
        sec_cnt_r <= '0;
        ALARM_OUT <= 1'b0;
      end else if (sup_cnt_r == 32'(SEC_CYCLES - 1)) begin
        sup_cnt_r <= '0;
        if (sec_cnt_r >= cfg_r.timeout_s) begin
          ALARM_OUT <= 1'b1;
        end else begin
          sec_cnt_r <= sec_cnt_r + 1'b1;
        end
      end else begin
        sup_cnt_r <= sup_cnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    ev = '0;
    ev[ST_FRAME] = frame_end_r && addr_ok_r;
    ev[ST_RXBYTE] = rx_byte.valid && state_r == S_RECV;
    ev[ST_TIMEOUT] = ALARM_OUT == 1'b0 && cfg_r.timeout_s != '0 &&
                     state_r != S_HOLD && sup_cnt_r == 32'(SEC_CYCLES - 1) &&
                     sec_cnt_r >= cfg_r.timeout_s;
    ev[ST_REFUSED] = byte_refused;
    ev[ST_TXDONE] = state_r == S_SEND && !tx_go_r && !tx_busy;
    ev[ST_DROP] = frame_end_r && !addr_ok_r;
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      status_r <= '0;
    end else if (RD_IN && ADDR_IN == REG_STATUS) begin
      status_r <= ev; // set wins over read-clear
    end else begin
      status_r <= status_r | ev;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(status_r & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cfg_r <= '0;
      mask_r <= '0;
      tx_data_r <= '0;
      tx_go_r <= 1'b0;
    end else begin
      if (WR_IN) begin
        unique case (ADDR_IN)
          REG_CTRL: begin
            cfg_r.station <= (WDATA_IN[7:0] > MAX_ADDR) ? MAX_ADDR : WDATA_IN[7:0];
            cfg_r.baud <= WDATA_IN[10:8];
            cfg_r.remote_en <= WDATA_IN[11];
            cfg_r.timeout_s <= (WDATA_IN[22:16] > MAX_TIMEOUT) ? MAX_TIMEOUT
                                                               : WDATA_IN[22:16];
          end
          REG_DELAY: cfg_r.resp_delay <= WDATA_IN[2:0];
          REG_MASK: mask_r <= WDATA_IN[ST_W-1:0];
          REG_TXDATA: tx_data_r <= WDATA_IN[7:0];
          REG_TXGO: tx_go_r <= WDATA_IN[0];
          default: ;
        endcase
      end
      if (tx_start) begin
        tx_go_r <= 1'b0;
      end
    end
  end

  // one byte per go pulse, only once the hold has elapsed
  assign tx_start = state_r == S_SEND && tx_go_r && !tx_busy;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      DE_OUT <= 1'b0;
    end else begin
      DE_OUT <= state_r == S_SEND;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      RDATA_OUT <= '0;
    end else if (RD_IN) begin
      unique case (ADDR_IN)
        REG_CTRL: RDATA_OUT <= {9'h0, cfg_r.timeout_s, 4'h0, cfg_r.remote_en,
                                cfg_r.baud, cfg_r.station};
        REG_DELAY: RDATA_OUT <= {29'h0, cfg_r.resp_delay};
        REG_STATUS: RDATA_OUT <= {26'h0, status_r};
        REG_MASK: RDATA_OUT <= {26'h0, mask_r};
        REG_RXDATA: RDATA_OUT <= {8'h0, func_r, first_r, rx_data_r};
        REG_TXDATA: RDATA_OUT <= {24'h0, tx_data_r};
        REG_STATE: RDATA_OUT <= {15'h0, is_me, nbytes_r, 3'h0, ALARM_OUT, state_r};
        default: RDATA_OUT <= READ_ZERO;
      endcase
    end else begin
      RDATA_OUT <= READ_ZERO;
    end
  end
endmodule // rslc_top

// ### rtl/rslc_tx.sv
// byte transmitter: start, 8 data, two stop bits
// assumes start is pulsed only while idle
`timescale 1ns/1ps
module rslc_tx
  import rslc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [BIT_W-1:0] bit_cyc_in,
  input wire logic start_in,
  input wire logic [7:0] data_in,
  output logic txd_out,
  output logic busy_out
);
  import rslc_pkg::*;

  logic [BIT_W-1:0] cnt_r;
  logic [3:0] bit_r;
  logic [10:0] sh_r;

  // ----------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r <= '0;
      bit_r <= '0;
      sh_r <= '1;
      busy_out <= 1'b0;
      txd_out <= 1'b1;
    end else if (!busy_out) begin
      txd_out <= 1'b1;
      if (start_in) begin
        sh_r <= {2'b11, data_in, 1'b0};
        busy_out <= 1'b1;
        bit_r <= '0;
        cnt_r <= '0;
      end
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end else if (bit_r == 4'(CHAR_BITS)) begin
      busy_out <= 1'b0;
    end else begin
      txd_out <= sh_r[0];
      sh_r <= {1'b1, sh_r[10:1]};
      bit_r <= bit_r + 1'b1;
      cnt_r <= bit_cyc_in - 1'b1;
    end
  end
endmodule // rslc_tx
